// ===== stpd_pkg.sv
// What this block does
// - powerdown puts every transmitter output high-impedance
// - receiver outputs always driven, every mode
// - transmitter output is inverse of its input
// - receiver output is inverse of line level
// - powerdown switches off charge pump enable
// - force sleep low means manual powerdown always
// - both force inputs high keeps device active
// - thirty seconds without transitions enters automatic powerdown
// - any tx_in or rx_line transition wakes from automatic powerdown
// - timer stays expired after powerdown until woken
// - raising force sleep alone does not wake
// - force active falling gives full thirty seconds
// - powerdown exit completes within one hundred microseconds
// - invalid flag low after thirty microseconds invalid
// - invalid flag never changes power state itself
// - invalid flag high when any receiver valid
// - tied force inputs act as one sleep control
// - invalid driving force inputs emulates simple powerdown
// - invalid flag rises within one microsecond
// - invalid detection works in every power mode
package stpd_pkg;

  localparam int unsigned CHAN_N        = 3;
  localparam longint unsigned CLK_HZ    = 64'd10_000_000;
  localparam longint unsigned IDLE_S    = 64'd30;
  localparam longint unsigned IDLE_CYC  = IDLE_S * CLK_HZ;
  localparam longint unsigned INV_US    = 64'd30;
  // strictly more than the time: one cycle past it
  localparam longint unsigned INV_CYC   = INV_US * CLK_HZ / 64'd1_000_000 + 64'd1;
  localparam longint unsigned WAKE_US   = 64'd100;
  // syncs, wake request and state register use part of the wake budget
  localparam longint unsigned WAKE_LAT  = 64'd5;
  localparam longint unsigned WAKE_CYC  = WAKE_US * CLK_HZ / 64'd1_000_000 - WAKE_LAT;
  localparam int unsigned CNT_W         = 32;

  typedef enum logic [1:0] {
    STPD_ACTIVE,
    STPD_SLEEP,
    STPD_WAKING
  } stpd_state_t;

  typedef struct packed {
    logic [CHAN_N-1:0] tx_line;
    logic [CHAN_N-1:0] tx_oe;
    logic [CHAN_N-1:0] rx_out;
  } stpd_lines_t;

endpackage

// ===== stpd_sync.sv
`timescale 1ns/100ps
module stpd_sync
  import stpd_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ===== stpd_timer.sv
`timescale 1ns/100ps
module stpd_timer
  import stpd_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // control
  input  wire logic             restart,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expired
);

  logic [CNT_W-1:0] cnt_reg;

  // saturates at limit; restart reloads and wins over expiry
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (restart) begin
      cnt_reg <= '0;
    end else if (cnt_reg < limit) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign expired = (cnt_reg >= limit) && !restart;

endmodule

// ===== stpd_ctrl.sv
`timescale 1ns/100ps
module stpd_ctrl
  import stpd_pkg::*;
#(
  parameter logic [CNT_W-1:0] IDLE_COUNT = CNT_W'(IDLE_CYC),
  parameter logic [CNT_W-1:0] INV_COUNT  = CNT_W'(INV_CYC),
  parameter logic [CNT_W-1:0] WAKE_COUNT = CNT_W'(WAKE_CYC)
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // power controls from host
  input  wire logic              force_active_in,
  input  wire logic              force_sleep_in,
  // logic-side transmitter inputs
  input  wire logic [CHAN_N-1:0] tx_in,
  // line-side receiver levels and validity sense
  input  wire logic [CHAN_N-1:0] rx_line,
  input  wire logic [CHAN_N-1:0] rx_valid,
  // line and logic outputs
  output stpd_lines_t            lines,
  // status
  output logic                   invalid_n,
  output logic                   pump_en,
  output logic                   powered
);

  logic [CHAN_N-1:0] tx_s;
  logic [CHAN_N-1:0] rx_s;
  logic [CHAN_N-1:0] val_s;
  logic [1:0]        frc_s;
  logic [CHAN_N-1:0] tx_prev_reg;
  logic [CHAN_N-1:0] rx_prev_reg;
  logic              fa_prev_reg;
  logic              edge_seen;
  logic              held_off_reg;
  logic              fa_fall;
  logic              idle_exp;
  logic              inv_exp;
  logic              any_valid;
  logic              idle_restart;
  logic              want_on;
  logic              wake_done;
  stpd_state_t       state_reg;
  stpd_state_t       state_next;

  stpd_sync #(.W(CHAN_N)) u_sync_tx (.clk_sys(clk_sys), .rstn(rstn), .d(tx_in),    .q(tx_s));
  stpd_sync #(.W(CHAN_N)) u_sync_rx (.clk_sys(clk_sys), .rstn(rstn), .d(rx_line),  .q(rx_s));
  stpd_sync #(.W(CHAN_N)) u_sync_vl (.clk_sys(clk_sys), .rstn(rstn), .d(rx_valid), .q(val_s));
  stpd_sync #(.W(2)) u_sync_frc (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .d      ({force_active_in, force_sleep_in}),
    .q      (frc_s)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_prev_reg <= '0;
      rx_prev_reg <= '0;
      fa_prev_reg <= 1'b0;
    end else begin
      tx_prev_reg <= tx_s;
      rx_prev_reg <= rx_s;
      fa_prev_reg <= frc_s[1];
    end
  end

  assign edge_seen = |((tx_s ^ tx_prev_reg) | (rx_s ^ rx_prev_reg));
  assign fa_fall   = !frc_s[1] && fa_prev_reg;

  // timer restarts on any tx or rx transition or force-active edge; held high keeps it fresh
  assign idle_restart = edge_seen || frc_s[1] || fa_fall;

  // timer only leaves expiry through a restart, so a powerdown keeps it expired
  stpd_timer u_idle (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .restart(idle_restart),
    .limit  (IDLE_COUNT),
    .expired(idle_exp)
  );

  // manual powerdown parks the idle logic timed out; raising force-sleep
  // alone must not wake, only a transition or force-active high releases it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      held_off_reg <= 1'b0;
    end else if (!frc_s[0]) begin
      held_off_reg <= 1'b1;
    end else if (idle_restart) begin
      held_off_reg <= 1'b0;
    end
  end

  assign any_valid = |val_s;

  stpd_timer u_inv (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .restart(any_valid),
    .limit  (INV_COUNT),
    .expired(inv_exp)
  );

  // free of power state, so it runs in every mode
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      invalid_n <= 1'b0;
    end else if (any_valid) begin
      invalid_n <= 1'b1;
    end else if (inv_exp) begin
      invalid_n <= 1'b0;
    end
  end

  // invalid flag feeds nothing here; only external wiring links it
  always_comb begin
    if (!frc_s[0]) begin
      want_on = 1'b0;
    end else if (frc_s[1]) begin
      want_on = 1'b1;
    end else begin
      want_on = !idle_exp && !held_off_reg;
    end
  end

  // wake delay: pump settles before transmitters drive
  stpd_timer u_wake (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .restart(state_reg != STPD_WAKING),
    .limit  (WAKE_COUNT),
    .expired(wake_done)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      STPD_ACTIVE: begin
        if (!want_on) begin
          state_next = STPD_SLEEP;
        end
      end
      STPD_SLEEP: begin
        if (want_on) begin
          state_next = STPD_WAKING;
        end
      end
      STPD_WAKING: begin
        if (!want_on) begin
          state_next = STPD_SLEEP;
        end else if (wake_done) begin
          state_next = STPD_ACTIVE;
        end
      end
      default: state_next = STPD_SLEEP;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= STPD_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pump_en <= 1'b0;
      powered <= 1'b0;
    end else begin
      pump_en <= (state_next != STPD_SLEEP);
      powered <= (state_next == STPD_ACTIVE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lines <= '0;
    end else begin
      lines.tx_line <= ~tx_s;
      lines.tx_oe   <= {CHAN_N{state_next == STPD_ACTIVE}};
      lines.rx_out  <= ~rx_s;
    end
  end

endmodule

// ===== stpd_host.sv
`timescale 1ns/100ps
module stpd_host (
  // clock and mode
  input  wire logic       clk_sys,
  input  wire logic [1:0] mode,
  input  wire logic [1:0] req,
  input  wire logic       invalid_n,
  // force controls
  output logic            force_active_in,
  output logic            force_sleep_in
);
  // updated on the falling edge, away from the device's sampling edge
  always @(negedge clk_sys) begin
    case (mode)
      2'h0: {force_active_in, force_sleep_in} <= {1'b1, req[0]};
      2'h1: {force_active_in, force_sleep_in} <= {2{req[0]}};
      2'h2: {force_active_in, force_sleep_in} <= {2{invalid_n}};
      default: {force_active_in, force_sleep_in} <= req;
    endcase
  end
endmodule

// ===== stpd_monitor.sv
`timescale 1ns/100ps
module stpd_monitor
  import stpd_pkg::*;
#(
  parameter logic [CNT_W-1:0] IDLE_COUNT = '0,
  parameter logic [CNT_W-1:0] INV_COUNT  = '0,
  parameter logic [CNT_W-1:0] WAKE_COUNT = '0
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // inputs
  input wire logic              force_active_in,
  input wire logic              force_sleep_in,
  input wire logic [CHAN_N-1:0] tx_in,
  input wire logic [CHAN_N-1:0] rx_line,
  input wire logic [CHAN_N-1:0] rx_valid,
  // outputs
  input wire stpd_lines_t       lines,
  input wire logic              invalid_n,
  input wire logic              pump_en,
  input wire logic              powered
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // windows sized for the short sim counts; input syncs add about three edges
  property p_oe; (!force_sleep_in)[*4] |-> lines.tx_oe == '0; endproperty
  a_oe: assert property (p_oe) else $error("tx enable wrong");
  property p_pump; powered |-> pump_en; endproperty
  a_pump: assert property (p_pump) else $error("pump off while on");
  property p_man; (!force_sleep_in)[*6] |-> !pump_en && !powered; endproperty
  a_man: assert property (p_man) else $error("awake in sleep");
  property p_on; (force_active_in && force_sleep_in)[*8] |-> ##[0:12] powered; endproperty
  a_on: assert property (p_on) else $error("not woken");
  property p_rx; $stable(rx_line)[*5] |-> lines.rx_out == ~rx_line; endproperty
  a_rx: assert property (p_rx) else $error("rx out wrong");
  property p_val; (|rx_valid)[*4] |-> invalid_n; endproperty
  a_val: assert property (p_val) else $error("flag stuck low");
  property p_inv; (rx_valid == '0)[*8] ##1 (rx_valid == '0)[*2] |-> !invalid_n; endproperty
  a_inv: assert property (p_inv) else $error("flag stuck high");
  property p_wake; $changed({tx_in, rx_line}) ##0 force_sleep_in[*6] |=> pump_en; endproperty
  a_wake: assert property (p_wake) else $error("edge did not wake");
endmodule
bind stpd_ctrl stpd_monitor #(
  .IDLE_COUNT(IDLE_COUNT),
  .INV_COUNT (INV_COUNT),
  .WAKE_COUNT(WAKE_COUNT)
) u_mon (
  .clk_sys        (clk_sys),
  .rstn           (rstn),
  .force_active_in(force_active_in),
  .force_sleep_in (force_sleep_in),
  .tx_in          (tx_in),
  .rx_line        (rx_line),
  .rx_valid       (rx_valid),
  .lines          (lines),
  .invalid_n      (invalid_n),
  .pump_en        (pump_en),
  .powered        (powered)
);

// ===== stpd_ctrl_tb.sv
`timescale 1ns/100ps
module stpd_ctrl_tb
  import stpd_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic [1:0]        mode = 2'h0;
  logic [1:0]        req = 2'h0;
  logic [CHAN_N-1:0] tx_in = 3'h0;
  logic [CHAN_N-1:0] rx_line = 3'h0;
  logic [CHAN_N-1:0] rx_valid = 3'h7;
  logic              force_active_in, force_sleep_in, invalid_n, pump_en, powered;
  stpd_lines_t       lines;
  logic [23:0]       notes[$];
  logic [23:0]       nt;
  int                num_errors = 0;
  int                n_tests = 0;
  int                seed = 32'h13ca57da;
  always #50 clk_sys = ~clk_sys;
  stpd_host u_host (.clk_sys, .mode, .req, .invalid_n, .force_active_in, .force_sleep_in);
  stpd_ctrl #(.IDLE_COUNT(32'h32), .INV_COUNT(32'h5), .WAKE_COUNT(32'h4)) DUT (
    .clk_sys, .rstn, .force_active_in, .force_sleep_in, .tx_in, .rx_line, .rx_valid,
    .lines, .invalid_n, .pump_en, .powered);
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // tx line is only meaningful while driving, so it is masked in sleep
  task automatic st(input int m, input int q, input int n, input logic p);
    @(negedge clk_sys);
    mode = 2'(m);
    req = 2'(q);
    repeat (n) @(negedge clk_sys);
    notes.push_back({p, p, |rx_valid, ~tx_in, {CHAN_N{p}}, ~rx_line, 3'h7, {CHAN_N{p}}, 6'h3f});
  endtask
  always @(posedge clk_sys) begin
    #1;
    if (notes.size() > 0) begin
      nt = notes.pop_front();
      chk({powered, pump_en, invalid_n, lines} & nt[11:0], nt[23:12] & nt[11:0]);
    end
  end
  // about five times the expected run
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    tx_in = $random(seed);
    st(0, 0, 20, 1'b0);
    st(0, 1, 20, 1'b1);
    rx_valid = 3'h0;
    st(1, 0, 20, 1'b0);
    tx_in = $random(seed);
    st(1, 1, 20, 1'b1);
    st(2, 0, 20, 1'b0);
    rx_valid = 3'h2;
    st(2, 0, 20, 1'b1);
    rx_line = $random(seed);
    st(3, 3, 20, 1'b1);
    st(3, 1, 40, 1'b1);
    st(3, 1, 30, 1'b0);
    st(3, 0, 20, 1'b0);
    st(3, 1, 20, 1'b0);
    tx_in = ~tx_in;
    st(3, 1, 20, 1'b1);
    st(3, 1, 70, 1'b0);
    rx_line = ~rx_line;
    st(3, 1, 20, 1'b1);
    // manual off while the idle timer is still fresh, then release force-sleep alone
    st(3, 0, 8, 1'b0);
    st(3, 1, 8, 1'b0);
    repeat (3) @(negedge clk_sys);
    wrap_up();
  end
endmodule
